/* File: core/spi_port.sv */
// Serial peripheral port with Avalon-MM registers, master and slave roles.
// Assumes pins arrive asynchronously and are synchronised here on i_clk.
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_cfg.svh"

module spi_port #(
  parameter int RATE_W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Avalon-MM slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Interrupt
  output logic o_irq,
  // Serial pins
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_nss
);
  generate
    if (RATE_W < 2 || RATE_W > 8) begin : g_bad_rate
      $error("RATE_W must lie between 2 and 8");
    end
  endgenerate

  localparam logic [RATE_W-1:0] MIN_HALF = RATE_W'(`SPI_MIN_HALF_CYC - 1);

  spi_shift_if sh ();

  spi_shifter u_shifter (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .bus(sh.eng)
  );

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] sck_q;
  logic [1:0] nss_q;
  logic [1:0] mosi_q;
  logic [1:0] miso_q;
  logic sck_prev;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sck_q <= 2'h0;
      nss_q <= 2'h3;
      mosi_q <= 2'h0;
      miso_q <= 2'h0;
      sck_prev <= 1'b0;
    end else begin
      sck_q <= {sck_q[0], i_sck};
      nss_q <= {nss_q[0], i_nss};
      mosi_q <= {mosi_q[0], i_mosi};
      miso_q <= {miso_q[0], i_miso};
      sck_prev <= sck_q[1];
    end
  end

  // --------------------------------------------------------------------------
  // Control state
  // --------------------------------------------------------------------------
  logic [3:0] flags, next_flags;
  logic multi, next_multi;
  logic master_enable_bit, next_master_enable_bit;
  logic pen, next_pen;
  logic cpha, next_cpha;
  logic cpol, next_cpol;
  logic [RATE_W-1:0] rate, next_rate;
  logic [3:0] mask, next_mask;
  logic [7:0] tx_buf, next_tx_buf;
  logic tx_full, next_tx_full;
  logic [7:0] rx_buf, next_rx_buf;
  logic rx_full, next_rx_full;
  spi_port_pkg::xfer_state_t state, next_state;
  logic [RATE_W-1:0] half_cnt, next_half_cnt;
  logic [3:0] edge_cnt, next_edge_cnt;
  logic sck_pin, next_sck_pin;
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;

  logic wr_go;
  logic rd_go;
  logic [RATE_W-1:0] half_lim;
  logic lead;
  logic trail;
  logic fault;
  logic [3:0] set_f;
  logic [3:0] clr_f;
  logic [7:0] ctrl_view;

  assign wr_go = i_avs_write & ack;
  assign rd_go = i_avs_read & ack;
  // The rate register is clamped so the master clock never beats its ceiling.
  assign half_lim = (rate < MIN_HALF) ? MIN_HALF : rate;
  assign fault = pen & master_enable_bit & multi & ~nss_q[1];
  assign ctrl_view = {flags, multi, (state == spi_port_pkg::XFER_RUN), master_enable_bit, pen};

  always_comb begin
    next_flags = flags;
    next_multi = multi;
    next_master_enable_bit = master_enable_bit;
    next_pen = pen;
    next_cpha = cpha;
    next_cpol = cpol;
    next_rate = rate;
    next_mask = mask;
    next_tx_buf = tx_buf;
    next_tx_full = tx_full;
    next_rx_buf = rx_buf;
    next_rx_full = rx_full;
    next_state = state;
    next_half_cnt = half_cnt;
    next_edge_cnt = edge_cnt;
    next_sck_pin = sck_pin;
    next_ack = 1'b0;
    next_rdata = rdata;
    set_f = 4'h0;
    clr_f = 4'h0;
    lead = 1'b0;
    trail = 1'b0;
    sh.load = 1'b0;
    sh.load_byte = tx_full ? tx_buf : `SPI_RST_BYTE;

    // Bus handshake: one wait cycle, read data latched in the first.
    if ((i_avs_read | i_avs_write) & ~ack) begin
      next_ack = 1'b1;
      unique case (i_avs_address)
        `SPI_OFS_CTRL: next_rdata = {24'h0, ctrl_view};
        `SPI_OFS_CFG: next_rdata = {26'h0, cpha, cpol, 4'h0};
        `SPI_OFS_RATE: next_rdata = {{(32 - RATE_W){1'b0}}, rate};
        `SPI_OFS_DATA: next_rdata = {24'h0, rx_buf};
        `SPI_OFS_MASK: next_rdata = {24'h0, mask, 4'h0};
        default: next_rdata = 32'h0;
      endcase
    end

    if (wr_go) begin
      unique case (i_avs_address)
        `SPI_OFS_CTRL: begin
          clr_f = i_avs_writedata[`SPI_BIT_DONE:`SPI_BIT_OVR];
          next_multi = i_avs_writedata[`SPI_BIT_MULTI];
          next_master_enable_bit = i_avs_writedata[`SPI_BIT_MASTER_ENABLE_BIT];
          next_pen = i_avs_writedata[`SPI_BIT_PEN];
        end
        `SPI_OFS_CFG: begin
          next_cpha = i_avs_writedata[`SPI_BIT_CPHA];
          next_cpol = i_avs_writedata[`SPI_BIT_CPOL];
        end
        `SPI_OFS_RATE: next_rate = i_avs_writedata[RATE_W-1:0];
        `SPI_OFS_DATA: begin
          if (tx_full) begin
            set_f[2] = 1'b1;
          end else begin
            next_tx_buf = i_avs_writedata[7:0];
            next_tx_full = 1'b1;
          end
        end
        `SPI_OFS_MASK: next_mask = i_avs_writedata[7:4];
        default: next_mask = mask;
      endcase
    end
    if (rd_go && i_avs_address == `SPI_OFS_DATA) begin
      next_rx_full = 1'b0;
    end

    // Edge finding: master from its own divider, slave from the synchronised pin.
    unique case (state)
      spi_port_pkg::XFER_IDLE: begin
        next_sck_pin = cpol;
        next_half_cnt = '0;
        next_edge_cnt = 4'h0;
        if (pen & master_enable_bit & tx_full & ~fault) begin
          sh.load = 1'b1;
          next_tx_full = 1'b0;
          next_state = spi_port_pkg::XFER_RUN;
        end else if (pen & ~master_enable_bit & ~nss_q[1] & (sck_q[1] == cpol)) begin
          sh.load = 1'b1;
          next_tx_full = 1'b0;
          next_state = spi_port_pkg::XFER_RUN;
        end
      end
      spi_port_pkg::XFER_RUN: begin
        if (master_enable_bit) begin
          // Rate register steers only the master divider.
          if (half_cnt == half_lim) begin
            next_half_cnt = '0;
            next_sck_pin = ~sck_pin;
            lead = (sck_pin == cpol);
            trail = ~lead;
            next_edge_cnt = edge_cnt + 4'h1;
            if (edge_cnt == 4'hF) begin
              next_state = spi_port_pkg::XFER_IDLE;
            end
          end else begin
            next_half_cnt = half_cnt + RATE_W'(1);
          end
        end else if (nss_q[1]) begin
          // Select released mid byte: the partial byte is dropped.
          next_state = spi_port_pkg::XFER_IDLE;
        end else if (sck_q[1] != sck_prev) begin
          lead = (sck_prev == cpol);
          trail = ~lead;
        end
        if (~pen) begin
          next_state = spi_port_pkg::XFER_IDLE;
        end
        if (sh.done & ~master_enable_bit) begin
          next_state = spi_port_pkg::XFER_IDLE;
        end
      end
    endcase

    sh.sample = cpha ? trail : lead;
    sh.shift = cpha ? lead : trail;

    if (sh.done) begin
      set_f[3] = 1'b1;
      if (~master_enable_bit & rx_full) begin
        set_f[0] = 1'b1;
      end else begin
        next_rx_buf = sh.rx_byte;
        next_rx_full = 1'b1;
      end
    end

    if (fault) begin
      set_f[1] = 1'b1;
      next_master_enable_bit = 1'b0;
      next_pen = 1'b0;
      next_state = spi_port_pkg::XFER_IDLE;
    end

    // A flag set in the same cycle as its clear stays set.
    next_flags = (flags & ~clr_f) | set_f;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      flags <= 4'(`SPI_RST_CTRL >> 4);
      multi <= 1'b0;
      master_enable_bit <= 1'b0;
      pen <= 1'b0;
      cpha <= 1'b0;
      cpol <= 1'b0;
      rate <= RATE_W'(`SPI_RST_RATE);
      mask <= `SPI_RST_MASK;
      tx_buf <= `SPI_RST_BYTE;
      tx_full <= 1'b0;
      rx_buf <= `SPI_RST_BYTE;
      rx_full <= 1'b0;
      state <= spi_port_pkg::XFER_IDLE;
      half_cnt <= '0;
      edge_cnt <= 4'h0;
      sck_pin <= 1'b0;
      ack <= 1'b0;
      rdata <= 32'h0;
    end else begin
      flags <= next_flags;
      multi <= next_multi;
      master_enable_bit <= next_master_enable_bit;
      pen <= next_pen;
      cpha <= next_cpha;
      cpol <= next_cpol;
      rate <= next_rate;
      mask <= next_mask;
      tx_buf <= next_tx_buf;
      tx_full <= next_tx_full;
      rx_buf <= next_rx_buf;
      rx_full <= next_rx_full;
      state <= next_state;
      half_cnt <= next_half_cnt;
      edge_cnt <= next_edge_cnt;
      sck_pin <= next_sck_pin;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // The master samples its input through the synchroniser, so the far end
  // must present data at least two system cycles before the sampling edge.
  assign sh.din = master_enable_bit ? miso_q[1] : mosi_q[1];
  assign sh.cpha = cpha;
  assign o_avs_readdata = rdata;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
  assign o_irq = |(flags & mask);
  assign o_sck = sck_pin;
  assign o_sck_oe = pen & master_enable_bit;
  assign o_mosi = sh.dout;
  assign o_mosi_oe = pen & master_enable_bit;
  assign o_miso = sh.dout;
  assign o_miso_oe = pen & ~master_enable_bit & ~nss_q[1];
endmodule // spi_port
`default_nettype wire

/* File: core/spi_port_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the serial port.
// Assumes a 40 MHz system clock and a 32-bit byte-addressed register bus.
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SPI_OFS_CTRL 5'h00
`define SPI_OFS_CFG 5'h04
`define SPI_OFS_RATE 5'h08
`define SPI_OFS_DATA 5'h0C
`define SPI_OFS_MASK 5'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SPI_BIT_DONE 7
`define SPI_BIT_WRITE_COLLISION_FLAG 6
`define SPI_BIT_MODE_FAULT_FLAG 5
`define SPI_BIT_OVR 4
`define SPI_BIT_MULTI 3
`define SPI_BIT_BUSY 2
`define SPI_BIT_MASTER_ENABLE_BIT 1
`define SPI_BIT_PEN 0
`define SPI_BIT_CPHA 5
`define SPI_BIT_CPOL 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SPI_RST_CTRL 8'h00
`define SPI_RST_CFG 8'h00
`define SPI_RST_RATE 8'h00
`define SPI_RST_MASK 4'h0
`define SPI_RST_BYTE 8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SPI_CLK_HZ 40000000
`define SPI_MAX_MASTER_HZ 12500000
// Least half period of the master clock, rounded up to whole system cycles.
`define SPI_MIN_HALF_CYC ((`SPI_CLK_HZ + 2 * `SPI_MAX_MASTER_HZ - 1) / (2 * `SPI_MAX_MASTER_HZ))

`endif

/* File: core/spi_port_pkg.sv */
// Types shared by the serial port modules.
// Assumes nothing of its surroundings.
package spi_port_pkg;
  typedef enum logic [0:0] {
    XFER_IDLE = 1'b0,
    XFER_RUN = 1'b1
  } xfer_state_t;
endpackage

/* File: core/spi_shift_if.sv */
// Carrier between the port controller and its bit shifter.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface spi_shift_if;
  logic load;
  logic [7:0] load_byte;
  logic cpha;
  logic sample;
  logic shift;
  logic din;
  logic dout;
  logic [7:0] rx_byte;
  logic done;
  modport ctl (output load, load_byte, cpha, sample, shift, din, input dout, rx_byte, done);
  modport eng (input load, load_byte, cpha, sample, shift, din, output dout, rx_byte, done);
endinterface
`default_nettype wire

/* File: core/spi_shifter.sv */
// Eight-bit shift engine: shifts out on shift strobes, samples on sample strobes.
// Assumes the controller issues one-cycle strobes already ordered by clock phase.
`timescale 1ns/1ps
`default_nettype none
module spi_shifter (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Controller side
  spi_shift_if.eng bus
);
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic [7:0] rx;
  logic [7:0] next_rx;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic dout;
  logic next_dout;
  logic done;
  logic next_done;

  always_comb begin
    next_tx = tx;
    next_rx = rx;
    next_cnt = cnt;
    next_dout = dout;
    next_done = 1'b0;
    if (bus.load) begin
      next_cnt = 3'h0;
      next_tx = bus.load_byte;
      // With phase 0 the first bit must be on the line before the first edge.
      if (!bus.cpha) begin
        next_dout = bus.load_byte[7];
        next_tx = {bus.load_byte[6:0], 1'b0};
      end
    end else begin
      if (bus.shift) begin
        next_dout = tx[7];
        next_tx = {tx[6:0], 1'b0};
      end
      if (bus.sample) begin
        next_rx = {rx[6:0], bus.din};
        next_cnt = cnt + 3'h1;
        next_done = (cnt == 3'h7);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tx <= `SPI_RST_BYTE;
      rx <= `SPI_RST_BYTE;
      cnt <= 3'h0;
      dout <= 1'b0;
      done <= 1'b0;
    end else begin
      tx <= next_tx;
      rx <= next_rx;
      cnt <= next_cnt;
      dout <= next_dout;
      done <= next_done;
    end
  end

  assign bus.dout = dout;
  assign bus.rx_byte = rx;
  assign bus.done = done;
endmodule // spi_shifter
`default_nettype wire

/* File: test/spi_far_end.sv */
// Far-end serial device: slave for the port's master role, master for its slave role.
// Assumes polarity 0, phase 0 or 1 in the port's master role, phase 0 in its slave role.
`timescale 1ns/1ps
`default_nettype none
module spi_far_end #(
  // 300 ns periods stay below a tenth of the 40 MHz clock, as unsynchronised masters must.
  parameter int HALF_NS = 150,
  // Start offset that keeps every link edge clear of a system clock edge.
  parameter int SKEW_NS = 5
) (
  // Wire levels on the link
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_miso,
  // Far-end drive
  output logic o_miso,
  output logic o_sck,
  output logic o_mosi,
  output logic o_nss
);
  logic [7:0] reply = 8'h00;
  logic [7:0] got = 8'h00;
  logic late = 1'b0;
  initial begin
    o_sck = 1'b0;
    o_mosi = 1'b0;
    o_nss = 1'b1;
  end
  assign o_miso = reply[7];
  // Phase 0 takes data on the rising edge, phase 1 on the falling edge.
  always @(posedge i_sck) begin
    if (late) begin
      reply <= {reply[6:0], ~reply[0]};
    end else begin
      got <= {got[6:0], i_mosi};
    end
  end
  always @(negedge i_sck) begin
    if (late) begin
      got <= {got[6:0], i_mosi};
    end else begin
      reply <= {reply[6:0], ~reply[0]};
    end
  end
  task automatic load(input logic [7:0] b, input logic ph);
    late <= ph;
    // With phase 1 the first rising edge already moves the reply on by one bit.
    reply <= ph ? {b[0], b[7:1]} : b;
  endtask
  task automatic select(input logic v);
    o_nss <= v;
  endtask
  task automatic send(input logic [7:0] b, output logic [7:0] r);
    #(SKEW_NS);
    o_nss = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      o_mosi = b[i];
      #(HALF_NS);
      o_sck = 1'b1;
      r[i] = i_miso;
      #(HALF_NS);
      o_sck = 1'b0;
    end
    #(HALF_NS);
    o_nss = 1'b1;
    // A released line shows the inverse of its last bit, so stale data cannot pass.
    o_mosi = ~b[0];
  endtask
endmodule // spi_far_end
`default_nettype wire

/* File: test/spi_port_chk.sv */
// Concurrent checks on the serial port's register bus and pins.
// Assumes the one-wait-state bus answer and 8-bit registers.
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_cfg.svh"
module spi_port_chk (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Register bus
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // Interrupt and pins
  input wire logic o_irq,
  input wire logic o_sck,
  input wire logic o_sck_oe,
  input wire logic o_mosi_oe,
  input wire logic o_miso_oe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  logic req;
  logic ack_rd;
  logic clr_wr;
  assign req = i_avs_read | i_avs_write;
  assign ack_rd = i_avs_read & ~o_avs_waitrequest;
  assign clr_wr = i_avs_write & ~o_avs_waitrequest
    & (i_avs_address == `SPI_OFS_CTRL | i_avs_address == `SPI_OFS_MASK);
  sequence s_wait;
    o_avs_waitrequest;
  endsequence
  sequence s_ack;
    !o_avs_waitrequest;
  endsequence
  AST_ONE_WAIT: assert property ($rose(req) |-> s_wait ##1 s_ack)
    else $error("bus answer not after one wait state");
  AST_IDLE_NO_WAIT: assert property (!req |-> !o_avs_waitrequest)
    else $error("waitrequest without a request");
  AST_UNMAPPED: assert property (ack_rd && i_avs_address > `SPI_OFS_MASK |-> o_avs_readdata == 0)
    else $error("unmapped read not zero");
  AST_UPPER_ZERO: assert property (ack_rd |-> o_avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  AST_RESET_QUIET: assert property ($fell(i_reset) |-> !(o_irq | o_sck_oe | o_miso_oe))
    else $error("outputs active after reset");
  AST_IRQ_HOLD: assert property ($fell(o_irq) |-> $past(clr_wr))
    else $error("irq dropped without a clearing write");
  AST_HALF_MIN: assert property (o_sck_oe && $changed(o_sck) |=> $stable(o_sck))
    else $error("serial clock half period below two cycles");
  AST_ROLE_OE: assert property (o_sck_oe |-> o_mosi_oe && !o_miso_oe)
    else $error("pin enables disagree with role");
endmodule // spi_port_chk
bind spi_port spi_port_chk chk (
  .i_clk, .i_reset, .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata,
  .o_avs_waitrequest, .o_irq, .o_sck, .o_sck_oe, .o_mosi_oe, .o_miso_oe
);
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench of the serial port driven over Avalon-MM.
// Assumes the far-end model spi_far_end and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_cfg.svh"
module tb;
  localparam logic [7:0] RATE = 8'h03;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [4:0] i_avs_address = 5'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h00000000;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest, o_irq, o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe;
  logic far_sck, far_mosi, far_miso, far_nss;
  logic sck_q = 1'b0;
  logic [7:0] rd, rx;
  int n_errors = 0;
  int checked = 0;
  int cnt = 0;
  int half_len = 0;
  wire logic sck_w = o_sck_oe ? o_sck : far_sck;
  wire logic mosi_w = o_mosi_oe ? o_mosi : far_mosi;
  wire logic miso_w = o_miso_oe ? o_miso : far_miso;
  always #12.5 i_clk = ~i_clk;
  spi_port uut (
    .i_clk, .i_reset, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .o_avs_readdata, .o_avs_waitrequest, .o_irq, .i_sck(sck_w), .o_sck, .o_sck_oe,
    .i_mosi(mosi_w), .o_mosi, .o_mosi_oe, .i_miso(miso_w), .o_miso, .o_miso_oe,
    .i_nss(far_nss)
  );
  spi_far_end far (
    .i_sck(sck_w), .i_mosi(mosi_w), .i_miso(miso_w), .o_miso(far_miso),
    .o_sck(far_sck), .o_mosi(far_mosi), .o_nss(far_nss)
  );
  // Length of the last serial clock half period, in system cycles.
  always @(posedge i_clk) begin
    sck_q <= o_sck;
    cnt <= (o_sck !== sck_q) ? 1 : cnt + 1;
    if (o_sck !== sck_q && o_sck_oe) half_len <= cnt;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_read <= ~wr;
    i_avs_write <= wr;
    i_avs_writedata <= {24'h000000, d};
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 64);
    if (n >= 64) n_errors++;
    rd = o_avs_readdata[7:0];
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic rdc(input string what, input logic [4:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(what, rd, exp);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    rdc("ctrl", `SPI_OFS_CTRL, 8'h00);
    rdc("cfg", `SPI_OFS_CFG, 8'h00);
    rdc("rate", `SPI_OFS_RATE, 8'h00);
    rdc("mask", `SPI_OFS_MASK, 8'h00);
    rdc("unmapped", 5'h14, 8'h00);
    check("irq", {7'h00, o_irq}, 8'h00);
    $display("done reset");
    bus(1'b1, `SPI_OFS_CFG, 8'h10);
    bus(1'b1, `SPI_OFS_CTRL, 8'h03);
    repeat (4) @(posedge i_clk);
    check("sck idle", {6'h00, o_sck_oe, o_sck}, 8'h03);
    bus(1'b1, `SPI_OFS_CTRL, 8'h00);
    bus(1'b1, `SPI_OFS_CFG, 8'h00);
    $display("done polarity");
    far.load(8'h3C, 1'b0);
    bus(1'b1, `SPI_OFS_RATE, RATE);
    bus(1'b1, `SPI_OFS_MASK, 8'hF0);
    bus(1'b1, `SPI_OFS_CTRL, 8'h03);
    bus(1'b1, `SPI_OFS_DATA, 8'hA5);
    for (int n = 0; n < 100 && rd[`SPI_BIT_DONE] !== 1'b1; n++) bus(1'b0, `SPI_OFS_CTRL, 8'h00);
    check("master done", {7'h00, rd[`SPI_BIT_DONE]}, 8'h01);
    repeat (20) @(posedge i_clk);
    check("far byte", far.got, 8'hA5);
    check("sck half", 8'(half_len), RATE + 8'h01);
    rdc("master rx", `SPI_OFS_DATA, 8'h3C);
    check("irq held", {7'h00, o_irq}, 8'h01);
    bus(1'b1, `SPI_OFS_CTRL, 8'h83);
    rdc("done cleared", `SPI_OFS_CTRL, 8'h03);
    check("irq dropped", {7'h00, o_irq}, 8'h00);
    $display("done master");
    bus(1'b1, `SPI_OFS_CTRL, 8'h00);
    bus(1'b1, `SPI_OFS_CFG, 8'h20);
    far.load(8'h96, 1'b1);
    bus(1'b1, `SPI_OFS_CTRL, 8'h03);
    bus(1'b1, `SPI_OFS_DATA, 8'h69);
    for (int n = 0; n < 100 && rd[`SPI_BIT_DONE] !== 1'b1; n++) bus(1'b0, `SPI_OFS_CTRL, 8'h00);
    check("phase1 done", {7'h00, rd[`SPI_BIT_DONE]}, 8'h01);
    repeat (20) @(posedge i_clk);
    check("phase1 far byte", far.got, 8'h69);
    rdc("phase1 rx", `SPI_OFS_DATA, 8'h96);
    bus(1'b1, `SPI_OFS_CTRL, 8'h80);
    bus(1'b1, `SPI_OFS_CFG, 8'h00);
    $display("done phase");
    bus(1'b1, `SPI_OFS_CTRL, 8'h01);
    bus(1'b1, `SPI_OFS_DATA, 8'h11);
    bus(1'b1, `SPI_OFS_DATA, 8'h22);
    rdc("collision", `SPI_OFS_CTRL, 8'h41);
    far.send(8'h5A, rx);
    check("slave tx", rx, 8'h11);
    repeat (8) @(posedge i_clk);
    rdc("slave done", `SPI_OFS_CTRL, 8'hC1);
    bus(1'b1, `SPI_OFS_CTRL, 8'hC1);
    far.send(8'hC3, rx);
    repeat (8) @(posedge i_clk);
    rdc("overrun", `SPI_OFS_CTRL, 8'h91);
    bus(1'b1, `SPI_OFS_MASK, 8'h00);
    @(posedge i_clk);
    check("irq masked", {7'h00, o_irq}, 8'h00);
    bus(1'b1, `SPI_OFS_MASK, 8'h10);
    @(posedge i_clk);
    check("irq overrun", {7'h00, o_irq}, 8'h01);
    rdc("old byte", `SPI_OFS_DATA, 8'h5A);
    bus(1'b1, `SPI_OFS_CTRL, 8'h91);
    $display("done slave");
    bus(1'b1, `SPI_OFS_MASK, 8'h20);
    bus(1'b1, `SPI_OFS_CTRL, 8'h0B);
    far.select(1'b0);
    repeat (8) @(posedge i_clk);
    rdc("mode fault", `SPI_OFS_CTRL, 8'h28);
    check("fault irq oe", {6'h00, o_irq, o_sck_oe}, 8'h02);
    far.select(1'b1);
    bus(1'b1, `SPI_OFS_CTRL, 8'h20);
    rdc("fault cleared", `SPI_OFS_CTRL, 8'h00);
    $display("done fault");
    finish_test();
  end
endmodule // tb
`default_nettype wire
